/* core/wlirq_cfg.svh */
// register offsets, field positions and reset values of the wake-up line unit
`ifndef WLIRQ_CFG_SVH
`define WLIRQ_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define WLIRQ_OFS_SOFT_FLAGS 8'h1C
`define WLIRQ_OFS_CONTROL 8'h24
`define WLIRQ_OFS_MASK_HIGH 8'h28
`define WLIRQ_OFS_MASK_LOW 8'h2C
`define WLIRQ_OFS_EDGE_HIGH 8'h30
`define WLIRQ_OFS_EDGE_LOW 8'h34
`define WLIRQ_OFS_PEND_HIGH 8'h38
`define WLIRQ_OFS_PEND_LOW 8'h3C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define WLIRQ_CTRL_WAKEUP_BIT 0
`define WLIRQ_CTRL_GIE_BIT 1
`define WLIRQ_CTRL_STOP_BIT 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WLIRQ_RST_BYTE 8'h00
`define WLIRQ_RST_LINES 16'h0000

`endif

/* core/wlirq_pkg.sv */
// types shared by the wake-up line interrupt unit
package wlirq_pkg;

   // ----------------------------------------------------------------
   // stop sequence tracker states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      WLIRQ_SEQ_IDLE = 3'b000,
      WLIRQ_SEQ_ONE = 3'b001,
      WLIRQ_SEQ_ONE_ZERO = 3'b010,
      WLIRQ_SEQ_ZERO = 3'b011,
      WLIRQ_SEQ_STOPPED = 3'b100
   } wlirq_seq_t;

   typedef logic [7:0] wlirq_byte_t;
   typedef logic [15:0] wlirq_lines_t;

   // ----------------------------------------------------------------
   // complete state of the unit
   // ----------------------------------------------------------------
   typedef struct packed {
      wlirq_byte_t soft_irq_flags;
      logic global_irq_enable;
      logic wakeup_mode_select;
      wlirq_lines_t line_mask;
      wlirq_lines_t edge_polarity;
      wlirq_lines_t line_pending;
      wlirq_lines_t sync1;
      wlirq_lines_t sync2;
      wlirq_lines_t prev;
      wlirq_seq_t seq;
      logic seq_abort;
      logic req_gap;
      wlirq_byte_t rdata;
   } wlirq_state_t;

endpackage

/* core/wlirq_unit.sv */
// wake-up line interrupt unit: 16 edge lines, soft flags, stop entry sequence
`include "wlirq_cfg.svh"

module wlirq_unit (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [15:0] WAKE_LINES,
   input wire logic IRQ_ACK,
   input wire logic [7:0] ADDR,
   input wire wlirq_pkg::wlirq_byte_t WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic IRQ_REQ,
   output logic STOP_REQ,
   output logic WAKE_EVENT
);
   import wlirq_pkg::*;

   wlirq_state_t st;
   wlirq_state_t next_st;

   logic [15:0] edge_hit;
   logic [15:0] armed;
   logic any_wake;
   logic stop_bit;
   logic stop_ok;
   logic wr_stop;
   logic wr_stop_val;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // write-zero-to-clear of one pending byte
   function automatic wlirq_byte_t clear_zero(input wlirq_byte_t cur, input wlirq_byte_t wd);
      clear_zero = cur & wd;
   endfunction

   // write strobe to a given offset
   function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
      hit = strobe && (a == ofs);
   endfunction

   // ----------------------------------------------------------------
   // combinational decode of lines and sequence
   // ----------------------------------------------------------------

   // selected edge per line, suppressed during writes to its own polarity byte
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         edge_hit[i] = (st.sync2[i] != st.prev[i])
            && (st.sync2[i] == st.edge_polarity[i]);
      end
      if (hit(WR, ADDR, `WLIRQ_OFS_EDGE_HIGH)) begin
         edge_hit[15:8] = 8'h00;
      end
      if (hit(WR, ADDR, `WLIRQ_OFS_EDGE_LOW)) begin
         edge_hit[7:0] = 8'h00;
      end
   end

   // line qualifiers
   assign armed = st.line_mask & st.line_pending;
   assign any_wake = st.wakeup_mode_select && (|armed);
   assign stop_ok = st.wakeup_mode_select && !(|armed) && (|st.line_mask);
   assign wr_stop = hit(WR, ADDR, `WLIRQ_OFS_CONTROL);
   assign wr_stop_val = WDATA[`WLIRQ_CTRL_STOP_BIT];
   assign stop_bit = (st.seq == WLIRQ_SEQ_ONE) || (st.seq == WLIRQ_SEQ_STOPPED);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------

   // all register, pending and sequence updates
   always_comb begin
      next_st = st;
      next_st.sync1 = WAKE_LINES;
      next_st.sync2 = st.sync1;
      next_st.prev = st.sync2;
      // software writes
      if (hit(WR, ADDR, `WLIRQ_OFS_SOFT_FLAGS)) begin
         next_st.soft_irq_flags = WDATA;
      end
      if (wr_stop) begin
         next_st.global_irq_enable = WDATA[`WLIRQ_CTRL_GIE_BIT];
         next_st.wakeup_mode_select = WDATA[`WLIRQ_CTRL_WAKEUP_BIT];
      end
      if (hit(WR, ADDR, `WLIRQ_OFS_MASK_HIGH)) begin
         next_st.line_mask[15:8] = WDATA;
      end
      if (hit(WR, ADDR, `WLIRQ_OFS_MASK_LOW)) begin
         next_st.line_mask[7:0] = WDATA;
      end
      if (hit(WR, ADDR, `WLIRQ_OFS_EDGE_HIGH)) begin
         next_st.edge_polarity[15:8] = WDATA;
      end
      if (hit(WR, ADDR, `WLIRQ_OFS_EDGE_LOW)) begin
         next_st.edge_polarity[7:0] = WDATA;
      end
      // pending: zero clears, then a new edge sets (set wins)
      if (hit(WR, ADDR, `WLIRQ_OFS_PEND_HIGH)) begin
         next_st.line_pending[15:8] = clear_zero(st.line_pending[15:8], WDATA);
      end
      if (hit(WR, ADDR, `WLIRQ_OFS_PEND_LOW)) begin
         next_st.line_pending[7:0] = clear_zero(st.line_pending[7:0], WDATA);
      end
      next_st.line_pending = next_st.line_pending | edge_hit;
      // partial clear with lines still armed: one low cycle for a fresh edge
      next_st.req_gap = (|(armed & ~next_st.line_pending))
         && (|(next_st.line_pending & st.line_mask));
      // acknowledged interrupt spoils a sequence in progress
      if (IRQ_ACK && (st.seq == WLIRQ_SEQ_ONE || st.seq == WLIRQ_SEQ_ONE_ZERO)) begin
         next_st.seq_abort = 1'b1;
      end
      // stop sequence tracker
      unique case (st.seq)
         WLIRQ_SEQ_IDLE: begin
            if (wr_stop && wr_stop_val) begin
               next_st.seq = WLIRQ_SEQ_ONE;
               next_st.seq_abort = 1'b0;
            end
         end
         WLIRQ_SEQ_ONE: begin
            if (wr_stop && !wr_stop_val) begin
               next_st.seq = WLIRQ_SEQ_ONE_ZERO;
            end
         end
         WLIRQ_SEQ_ONE_ZERO: begin
            if (wr_stop && wr_stop_val) begin
               if (stop_ok && !st.seq_abort && !IRQ_ACK) begin
                  next_st.seq = WLIRQ_SEQ_STOPPED;
               end else begin
                  next_st.seq = WLIRQ_SEQ_IDLE;
               end
            end else if (wr_stop) begin
               next_st.seq = WLIRQ_SEQ_IDLE;
            end
         end
         WLIRQ_SEQ_ZERO: begin
            next_st.seq = WLIRQ_SEQ_IDLE;
         end
         WLIRQ_SEQ_STOPPED: begin
            if (any_wake) begin
               next_st.seq = WLIRQ_SEQ_IDLE;
            end else if (wr_stop && !wr_stop_val) begin
               next_st.seq = WLIRQ_SEQ_IDLE;
            end
         end
         default: begin
            next_st.seq = WLIRQ_SEQ_IDLE;
         end
      endcase
      // read data, one cycle later
      next_st.rdata = 8'h00;
      if (RD) begin
         unique case (ADDR)
            `WLIRQ_OFS_SOFT_FLAGS: next_st.rdata = st.soft_irq_flags;
            `WLIRQ_OFS_CONTROL: next_st.rdata = {5'h00, stop_bit, st.global_irq_enable,
               st.wakeup_mode_select};
            `WLIRQ_OFS_MASK_HIGH: next_st.rdata = st.line_mask[15:8];
            `WLIRQ_OFS_MASK_LOW: next_st.rdata = st.line_mask[7:0];
            `WLIRQ_OFS_EDGE_HIGH: next_st.rdata = st.edge_polarity[15:8];
            `WLIRQ_OFS_EDGE_LOW: next_st.rdata = st.edge_polarity[7:0];
            `WLIRQ_OFS_PEND_HIGH: next_st.rdata = st.line_pending[15:8];
            `WLIRQ_OFS_PEND_LOW: next_st.rdata = st.line_pending[7:0];
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------

   // asynchronous reset to constants
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   // level request: a clear of some pending lines with others left armed gives a
   // low cycle, so the channel sees a fresh rising edge
   assign IRQ_REQ = st.global_irq_enable && !st.req_gap
      && ((|armed) || (|st.soft_irq_flags));
   assign STOP_REQ = (st.seq == WLIRQ_SEQ_STOPPED);
   assign WAKE_EVENT = any_wake;
   assign RDATA = st.rdata;

endmodule

/* tb/wlirq_checker.sv */
// port assertions for the wake-up line interrupt unit
module wlirq_checker (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [15:0] WAKE_LINES,
   input wire logic IRQ_ACK,
   input wire logic [7:0] ADDR,
   input wire wlirq_pkg::wlirq_byte_t WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic IRQ_REQ,
   input wire logic STOP_REQ,
   input wire logic WAKE_EVENT
);
   import wlirq_pkg::*;
   // one clock domain, reset disables every check
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   read_quiet_a: assert property (!$past(RD) |-> RDATA == 8'h00)
      else $error("read data not idle");
   stop_cause_a: assert property ($rose(STOP_REQ) |-> $past(WR) && $past(ADDR) == 8'h24 && $past(WDATA[2]))
      else $error("stop without final write");
   stop_clean_a: assert property ($rose(STOP_REQ) |-> !$past(WAKE_EVENT) && !$past(IRQ_ACK))
      else $error("stop despite armed line or ack");
   wake_stop_a: assert property (STOP_REQ && WAKE_EVENT && !WR |=> !STOP_REQ)
      else $error("wake did not clear stop");
   stop_hold_a: assert property (STOP_REQ && !WAKE_EVENT && !(WR && ADDR == 8'h24) |=> STOP_REQ)
      else $error("stop dropped alone");
   stop_read_a: assert property (STOP_REQ && !WAKE_EVENT && RD && ADDR == 8'h24 |=> RDATA[2])
      else $error("stop bit reads 0 in stop");
   ctrl_resv_a: assert property (RD && ADDR == 8'h24 |=> RDATA[7:3] == 5'h00)
      else $error("control reserved bits set");
   wake_mode_a: assert property (WAKE_EVENT && RD && ADDR == 8'h24 |=> RDATA[0])
      else $error("wake event outside wake mode");
   unmapped_a: assert property (RD && !(ADDR inside {8'h1C, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C})
      |=> RDATA == 8'h00)
      else $error("unmapped read not zero");
endmodule

bind wlirq_unit wlirq_checker i_chk (.CORE_CLK(CORE_CLK), .RST(RST), .WAKE_LINES(WAKE_LINES), .IRQ_ACK(IRQ_ACK),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_REQ(IRQ_REQ), .STOP_REQ(STOP_REQ),
   .WAKE_EVENT(WAKE_EVENT));

/* tb/wlirq_partner.sv */
// far side: wake-up pins and an interrupt controller that acknowledges
module wlirq_partner (
   input wire logic clk,
   input wire logic irq_req,
   input wire logic ack_on,
   input wire logic [15:0] pins,
   output logic irq_ack,
   output logic [15:0] wake_lines
);
   timeunit 1ns;
   timeprecision 1ps;
   logic seen = 1'b0;
   logic ack_q = 1'b0;
   // one-cycle acknowledge on each fresh request edge
   always @(posedge clk) begin
      seen <= irq_req;
      ack_q <= ack_on && irq_req && !seen;
   end
   assign irq_ack = ack_q;
   assign wake_lines = pins; // clean edges only
endmodule

/* tb/wlirq_unit_bench.sv */
// self-checking bench for the wake-up line interrupt unit
module wlirq_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import wlirq_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, ack_on = 0, irq_ack, irq, stop, wake;
   logic [7:0] addr = 8'h00, rdata;
   wlirq_byte_t wdata = 8'h00;
   logic [15:0] pins = 16'h0000, lines;
   logic [7:0] ofs [9] = '{8'h1C, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h20};
   int fails = 0, tests_run = 0;
   // free-running clock
   always #5 clk = ~clk;
   wlirq_unit i_dut (.CORE_CLK(clk), .RST(rst), .WAKE_LINES(lines), .IRQ_ACK(irq_ack), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .IRQ_REQ(irq), .STOP_REQ(stop), .WAKE_EVENT(wake));
   wlirq_partner i_far (.clk(clk), .irq_req(irq), .ack_on(ack_on), .pins(pins), .irq_ack(irq_ack),
      .wake_lines(lines));
   task automatic chk(input string n, input logic [7:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wrr(input logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", rdata, exp);
   endtask
   task automatic pin(input int b, input logic v);
      @(posedge clk);
      pins[b] <= v;
      repeat (5) @(posedge clk);
      #1;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wrr(8'h20, 8'hFF);
      foreach (ofs[i]) rdc(ofs[i], 8'h00);
      $display("test reset done");
      wrr(8'h34, 8'h01);
      wrr(8'h2C, 8'h03);
      pin(0, 1'b1);
      pin(1, 1'b1);
      rdc(8'h3C, 8'h01);
      pin(1, 1'b0);
      wrr(8'h3C, 8'hFF);
      rdc(8'h3C, 8'h03);
      chk("irq", irq, 8'h00);
      wrr(8'h24, 8'h02);
      #1 chk("irq", irq, 8'h01);
      wrr(8'h3C, 8'h02);
      #1 chk("irq", irq, 8'h00);
      @(posedge clk);
      #1 chk("irq", irq, 8'h01);
      wrr(8'h3C, 8'h00);
      #1 chk("irq", irq, 8'h00);
      wrr(8'h24, 8'h00);
      wrr(8'h1C, 8'hA5);
      rdc(8'h1C, 8'hA5);
      chk("irq", irq, 8'h00);
      wrr(8'h24, 8'h02);
      #1 chk("irq", irq, 8'h01);
      wrr(8'h1C, 8'h00);
      $display("test lines done");
      wrr(8'h24, 8'h03);
      wrr(8'h24, 8'h07);
      rdc(8'h24, 8'h07);
      wrr(8'h24, 8'h03);
      rdc(8'h24, 8'h03);
      wrr(8'h24, 8'h07);
      #1 chk("stop", stop, 8'h01);
      repeat (6) @(posedge clk);
      #1 chk("stop", stop, 8'h01);
      pin(0, 1'b0);
      pin(0, 1'b1);
      chk("stop", stop, 8'h00);
      chk("wake", wake, 8'h01);
      rdc(8'h24, 8'h03);
      wrr(8'h24, 8'h07);
      wrr(8'h24, 8'h03);
      wrr(8'h24, 8'h07);
      #1 chk("stop", stop, 8'h00);
      wrr(8'h24, 8'h02);
      #1 chk("wake", wake, 8'h00);
      wrr(8'h3C, 8'h00);
      wrr(8'h24, 8'h06);
      wrr(8'h24, 8'h02);
      wrr(8'h24, 8'h06);
      #1 chk("stop", stop, 8'h00);
      wrr(8'h24, 8'h07);
      wrr(8'h24, 8'h03);
      wrr(8'h24, 8'h03);
      wrr(8'h24, 8'h07);
      #1 chk("stop", stop, 8'h00);
      ack_on <= 1'b1;
      wrr(8'h1C, 8'h01);
      wrr(8'h1C, 8'h00);
      wrr(8'h24, 8'h03);
      wrr(8'h24, 8'h07);
      #1 chk("stop", stop, 8'h00);
      $display("test stop done");
      close_out();
   end
   // watchdog far beyond the roughly 140 cycles of the tests
   initial begin
      #50us;
      fails++;
      close_out();
   end
endmodule
